// File: src/spg_gate_ctrl.sv
// serial pad gate control: wishbone register gating two serial ports' pads
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/100ps
`include "spg_cfg.svh"

module spg_gate_ctrl #(
  parameter bit HAS_PORT_B = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // wishbone slave
  input spg_pkg::spg_wb_req_type wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial port outputs before the pads
  input spg_pkg::spg_pad_type port_a_serial_clock,
  input spg_pkg::spg_pad_type port_a_serial_data_out,
  input spg_pkg::spg_pad_type port_b_serial_clock,
  input spg_pkg::spg_pad_type port_b_serial_data_out,
  // pad drivers
  output spg_pkg::spg_pad_type pad_a_clock,
  output spg_pkg::spg_pad_type pad_a_data,
  output spg_pkg::spg_pad_type pad_b_clock,
  output spg_pkg::spg_pad_type pad_b_data
);
  import spg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [`SPG_REG_W-1:0] serial_pad_gate_control;
  logic [`SPG_REG_W-1:0] impl_mask;
  logic [`SPG_REG_W-1:0] next_gate;
  logic req_live;
  logic wr_take;

  function automatic logic addr_hit(input logic [7:0] adr);
    addr_hit = (adr == `SPG_GATE_ADDR);
  endfunction

  // port b bits vanish on variants without that port
  assign impl_mask = HAS_PORT_B ? `SPG_GATE_MASK : (`SPG_GATE_MASK & ~`SPG_PORT_B_MASK);

  assign req_live = wb_req.cyc & wb_req.stb;
  // the write lands on the edge where the master sees ack
  assign wr_take = req_live & wb_req.we & wb_ack_o & addr_hit(wb_req.adr) & wb_req.sel[`SPG_GATE_LANE];

  // unimplemented bits are never stored, so they cannot leak into a read
  assign next_gate = wb_req.dat[`SPG_REG_W-1:0] & impl_mask;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, dropped the next

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req_live & ~wb_ack_o;
    end
  end

  // unmapped addresses are acked and read zero so a stray access never hangs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req_live & ~wb_ack_o & ~wb_req.we & addr_hit(wb_req.adr)) begin
      wb_dat_o <= {16'h0000, serial_pad_gate_control & impl_mask};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      serial_pad_gate_control <= `SPG_GATE_RESET;
    end else if (wr_take) begin
      serial_pad_gate_control <= next_gate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad gating, one registered channel per gating bit

  spg_pad_type port_sig [`SPG_CHANNELS];
  spg_pad_type pad_sig [`SPG_CHANNELS];

  assign port_sig[0] = port_a_serial_clock;
  assign port_sig[1] = port_a_serial_data_out;
  assign port_sig[2] = port_b_serial_clock;
  assign port_sig[3] = port_b_serial_data_out;

  generate
    for (genvar ch = 0; ch < `SPG_CHANNELS; ch++) begin : g_chan
      spg_pad_gate u_gate (
        .core_clk(core_clk),
        .resetn(resetn),
        .port_sig(port_sig[ch]),
        .block(serial_pad_gate_control[`SPG_GATE_LSB + ch]),
        .pad(pad_sig[ch])
      );
    end
  endgenerate

  // the pad outputs are the flip-flops inside each gate cell
  assign pad_a_clock = pad_sig[0];
  assign pad_a_data = pad_sig[1];
  assign pad_b_clock = pad_sig[2];
  assign pad_b_data = pad_sig[3];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_gate_write;
    wb_req.cyc & wb_req.stb & wb_req.we & wb_ack_o & addr_hit(wb_req.adr) & wb_req.sel[`SPG_GATE_LANE];
  endsequence

  sequence s_gate_read;
    wb_req.cyc & wb_req.stb & ~wb_req.we & ~wb_ack_o & addr_hit(wb_req.adr);
  endsequence

  property p_port_b_data_block;
    @(posedge core_clk) disable iff (!resetn)
      serial_pad_gate_control[`SPG_BIT_B_DATA] |=> (pad_b_data == '0);
  endproperty
  a_port_b_data_block: assert property (p_port_b_data_block)
    else $error("port b data reached its pad while blocked");

  // resetn in the antecedent keeps the release edge, whose pads still hold reset, out of the pass checks
  property p_port_b_clock_pass;
    @(posedge core_clk) disable iff (!resetn)
      resetn && !serial_pad_gate_control[`SPG_BIT_B_CLOCK] |=> (pad_b_clock == $past(port_b_serial_clock));
  endproperty
  a_port_b_clock_pass: assert property (p_port_b_clock_pass)
    else $error("port b clock not passed to its pad");

  property p_port_b_clock_block;
    @(posedge core_clk) disable iff (!resetn)
      serial_pad_gate_control[`SPG_BIT_B_CLOCK] |=> !pad_b_clock.oe && !pad_b_clock.out;
  endproperty
  a_port_b_clock_block: assert property (p_port_b_clock_block)
    else $error("port b clock reached its pad while blocked");

  property p_port_a_data_gate;
    @(posedge core_clk) disable iff (!resetn)
      resetn |=> (pad_a_data == ($past(serial_pad_gate_control[`SPG_BIT_A_DATA]) ? '0 : $past(port_a_serial_data_out)));
  endproperty
  a_port_a_data_gate: assert property (p_port_a_data_gate)
    else $error("port a data pad does not follow its gating bit");

  logic gate_a_clock_set;
  assign gate_a_clock_set = serial_pad_gate_control[`SPG_BIT_A_CLOCK];

  property p_port_a_clock_gate;
    @(posedge core_clk) disable iff (!resetn)
      s_gate_write ##1 gate_a_clock_set ##1 1'b1 |-> (pad_a_clock == '0);
  endproperty
  a_port_a_clock_gate: assert property (p_port_a_clock_gate)
    else $error("port a clock pad not released after blocking write");

  property p_port_a_clock_pass;
    @(posedge core_clk) disable iff (!resetn)
      resetn && !gate_a_clock_set |=> (pad_a_clock == $past(port_a_serial_clock));
  endproperty
  a_port_a_clock_pass: assert property (p_port_a_clock_pass)
    else $error("port a clock not passed to its pad");

  property p_port_b_data_pass;
    @(posedge core_clk) disable iff (!resetn)
      resetn && !serial_pad_gate_control[`SPG_BIT_B_DATA] |=> (pad_b_data == $past(port_b_serial_data_out));
  endproperty
  a_port_b_data_pass: assert property (p_port_b_data_pass)
    else $error("port b data not passed to its pad");

  property p_unimpl_read_zero;
    @(posedge core_clk) disable iff (!resetn)
      s_gate_read |=> wb_ack_o && (wb_dat_o[31:12] == 20'h00000) && (wb_dat_o[7:0] == 8'h00);
  endproperty
  a_unimpl_read_zero: assert property (p_unimpl_read_zero)
    else $error("unimplemented bits read nonzero");

  property p_write_stores_field;
    @(posedge core_clk) disable iff (!resetn)
      s_gate_write |=> (serial_pad_gate_control == ($past(wb_req.dat[15:0]) & impl_mask));
  endproperty
  a_write_stores_field: assert property (p_write_stores_field)
    else $error("write stored the wrong field value");

  property p_no_port_b_bits;
    @(posedge core_clk) disable iff (!resetn)
      !HAS_PORT_B |-> (serial_pad_gate_control[`SPG_BIT_B_DATA:`SPG_BIT_B_CLOCK] == 2'b00);
  endproperty
  a_no_port_b_bits: assert property (p_no_port_b_bits)
    else $error("port b gating bits set on a variant without port b");

  property p_reset_clear;
    @(posedge core_clk) disable iff (!resetn)
      !$past(resetn) |-> (serial_pad_gate_control == `SPG_GATE_RESET) && !wb_ack_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("gating bits not clear after reset");

  property p_ack_one_cycle;
    @(posedge core_clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle)
    else $error("ack held longer than one cycle");

  // read data must not linger past the ack cycle, or a later master could latch it
  property p_read_data_idle;
    @(posedge core_clk) disable iff (!resetn)
      !wb_ack_o |-> (wb_dat_o == 32'h0000_0000);
  endproperty
  a_read_data_idle: assert property (p_read_data_idle)
    else $error("read data not zero outside the ack cycle");

endmodule

// File: src/spg_cfg.svh
// constants for the serial pad gate control block
`ifndef SPG_CFG_SVH
`define SPG_CFG_SVH

// register byte address on the wishbone bus
`define SPG_GATE_ADDR 8'h00
// width of the control register as seen by software
`define SPG_REG_W 16
// reset value of the control register
`define SPG_GATE_RESET 16'h0000
// implemented gating bits
`define SPG_GATE_MASK 16'h0F00
// gating bits that exist only with the second serial port
`define SPG_PORT_B_MASK 16'h0C00
// field positions
`define SPG_BIT_A_CLOCK 8
`define SPG_BIT_A_DATA 9
`define SPG_BIT_B_CLOCK 10
`define SPG_BIT_B_DATA 11
// number of gated pad channels and the lowest gating bit
`define SPG_CHANNELS 4
`define SPG_GATE_LSB 8
// byte lane that carries the gating bits
`define SPG_GATE_LANE 1

`endif

// File: src/spg_pkg.sv
// types shared by the serial pad gate control block
package spg_pkg;

  // one classic wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } spg_wb_req_type;

  // one serial output on its way to a pad
  typedef struct packed {
    logic out;
    logic oe;
  } spg_pad_type;

endpackage

// File: src/spg_pad_gate.sv
// one gated pad channel: passes or blocks a serial output, registered
`timescale 1ns/100ps

module spg_pad_gate
  import spg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // from the serial port and the control register
  input spg_pkg::spg_pad_type port_sig,
  input wire logic block,
  // to the pad
  output spg_pkg::spg_pad_type pad
);

  // a blocked channel releases the pad rather than holding it low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pad <= '0;
    end else if (block) begin
      pad <= '0;
    end else begin
      pad <= port_sig;
    end
  end

endmodule

// File: src/unused_placeholder_removed.sv
// reserved: holds no logic of the serial pad gate control block

// File: verif/spg_spi_far_model.sv
// far side model: external serial parts watching the four pads
`timescale 1ns/100ps

module spg_spi_far_model (
  // clock
  input wire logic core_clk,
  // pads, two bits each as {out, oe}, channel 0 lowest
  input wire logic [7:0] pad_bus,
  // level each part sees on its wire
  output logic [3:0] wire_lvl
);
  logic [3:0] last_lvl = 4'h0;

  // released wires have no pull, so show the inverse of the last driven level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wire_lvl[i] = pad_bus[2*i] ? pad_bus[2*i+1] : ~last_lvl[i];
    end
  end

  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (pad_bus[2*i]) begin
        last_lvl[i] <= pad_bus[2*i+1];
      end
    end
  end
endmodule

// File: verif/spg_gate_ctrl_tb_top.sv
// bench for the serial pad gate control block
`timescale 1ns/100ps
`include "spg_cfg.svh"

module spg_gate_ctrl_tb_top;
  import spg_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  spg_wb_req_type wb_req = '0;
  logic [7:0] port_bus = 8'hFF;
  wire logic [7:0] pad0;
  wire logic [7:0] pad1;
  wire logic [31:0] dat0;
  wire logic [31:0] dat1;
  wire logic ack0;
  wire logic [3:0] wire_lvl;
  logic [31:0] rd0;
  logic [31:0] rd1;
  int num_errors = 0;
  int check_count = 0;
  int cyc_count = 0;

  always #20 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  spg_gate_ctrl #(.HAS_PORT_B(1'b1)) dut (.core_clk(core_clk), .resetn(resetn), .wb_req(wb_req),
    .wb_dat_o(dat0), .wb_ack_o(ack0), .port_a_serial_clock(port_bus[1:0]),
    .port_a_serial_data_out(port_bus[3:2]), .port_b_serial_clock(port_bus[5:4]),
    .port_b_serial_data_out(port_bus[7:6]), .pad_a_clock(pad0[1:0]), .pad_a_data(pad0[3:2]),
    .pad_b_clock(pad0[5:4]), .pad_b_data(pad0[7:6]));
  // variant without the second port shares the bus and answers in step
  spg_gate_ctrl #(.HAS_PORT_B(1'b0)) dut_a_only (.core_clk(core_clk), .resetn(resetn), .wb_req(wb_req),
    .wb_dat_o(dat1), .wb_ack_o(), .port_a_serial_clock(port_bus[1:0]),
    .port_a_serial_data_out(port_bus[3:2]), .port_b_serial_clock(port_bus[5:4]),
    .port_b_serial_data_out(port_bus[7:6]), .pad_a_clock(pad1[1:0]), .pad_a_data(pad1[3:2]),
    .pad_b_clock(pad1[5:4]), .pad_b_data(pad1[7:6]));
  spg_spi_far_model far (.core_clk(core_clk), .pad_bus(pad0), .wire_lvl(wire_lvl));

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ack is read before the edge's own updates land, so this is the sampled value
  // waits as long as it takes; only the cycle ceiling below ends a hang
  task automatic wb_go(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
    do begin
      @(posedge core_clk);
    end while (ack0 !== 1'b1);
    rd0 = dat0;
    rd1 = dat1;
    wb_req <= '0;
    @(posedge core_clk);
  endtask

  function automatic logic [31:0] exp_pads(input logic [3:0] blk);
    exp_pads = 32'h0;
    for (int i = 0; i < 4; i++) exp_pads[2*i+:2] = blk[i] ? 2'h0 : port_bus[2*i+:2];
  endfunction

  always @(posedge core_clk) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("pads after reset", exp_pads(4'h0), {24'h0, pad0});
    check("wire levels", 32'hF, {28'h0, wire_lvl});
    wb_go(1'b0, `SPG_GATE_ADDR, 32'h0);
    check("reset value", `SPG_GATE_RESET, rd0);
    for (int i = 0; i < 4; i++) begin
      port_bus <= 8'h5B ^ 8'(i * 8'h11);
      wb_go(1'b1, `SPG_GATE_ADDR, 32'h1 << (8 + i));
      @(posedge core_clk);
      check("pads one gated", exp_pads(4'h1 << i), {24'h0, pad0});
      wb_go(1'b0, `SPG_GATE_ADDR, 32'h0);
      check("readback", 32'h1 << (8 + i), rd0);
      check("readback no port b", (32'h1 << (8 + i)) & 32'h0300, rd1);
    end
    wb_go(1'b1, `SPG_GATE_ADDR, 32'hFFFFFFFF);
    @(posedge core_clk);
    check("pads all gated", exp_pads(4'hF), {24'h0, pad0});
    check("pads no port b", exp_pads(4'h3), {24'h0, pad1});
    wb_go(1'b1, 8'h04, 32'h0);
    wb_go(1'b0, `SPG_GATE_ADDR, 32'h0);
    check("unimplemented bits", 32'h00000F00, rd0);
    check("variant bits", 32'h00000300, rd1);
    wb_go(1'b0, 8'h04, 32'h0);
    check("unmapped read", 32'h0, rd0);
    // a reset in mid-run must clear every gate again
    port_bus <= 8'h77;
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("pads after mid reset", exp_pads(4'h0), {24'h0, pad0});
    check("pads after mid reset no port b", exp_pads(4'h0), {24'h0, pad1});
    check("wire levels driven", 32'h5, {28'h0, wire_lvl});
    wb_go(1'b0, `SPG_GATE_ADDR, 32'h0);
    check("value after mid reset", `SPG_GATE_RESET, rd0);
    wb_go(1'b1, `SPG_GATE_ADDR, 32'h00000F00);
    @(posedge core_clk);
    check("pads gated after mid reset", exp_pads(4'hF), {24'h0, pad0});
    check("wire levels released", 32'hA, {28'h0, wire_lvl});
    report_and_stop();
  end
endmodule
